// file: erc_ctrl.sv
// Contract
// - stand-alone output: select bit 0 gives 5.0 V, 1 gives 3.3 V
// - load-sharing configuration ignores the voltage-select bit
// - stand-alone chosen by on bit in Normal mode with share bit zero
// - share bit written one selects load sharing; on bit then has no effect
// - first chosen configuration locks, survives soft reset, cleared by power loss
// - locked stand-alone still switches on/off; change attempts ignored silently
// - locked load sharing: change attempts set command-fail, configuration kept
// - stand-alone: off in Init/Fail-Safe, settable in Normal, held otherwise
// - load sharing: off Init/Sleep/Fail-Safe, on in Restart and in Normal
// - Stop mode disables load sharing unless share-in-stop bit set
// - share bit stays set in Stop; sharing resumes in Normal automatically
// - supply undervoltage switches output off unless keep-on bit set
// - Stop mode adds high-power stage above rise threshold, drops below fall
// - Normal mode runs only the high-power stage
// - stand-alone shunt threshold limits current, sets overcurrent flag, clear when gone
// - stand-alone output undervoltage sets the undervoltage status flag
// - output undervoltage handling applies in stand-alone configuration only
// - load sharing never raises output undervoltage flag
// - load sharing has no current limit and never sets overcurrent flag
// - load sharing output shuts down when Fail-Safe is entered
`timescale 1ns/10ps
`default_nettype none
`include "erc_params.svh"

module erc_ctrl #(
    parameter int ADDR_WIDTH = 8
) (
    // clock and resets
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                porN,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]         pwdata,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    // device state and analog sensing
    input  wire erc_pkg::erc_mode_e  devMode,
    input  wire erc_pkg::erc_sense_s sense,
    // regulator controls
    output var  erc_pkg::erc_drive_s drive
);

    initial begin
        if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) begin
            $error("erc_ctrl: ADDR_WIDTH must be 4..32");
        end
    end

    // power-on storage
    erc_pkg::erc_cfg_e cfg_q, cfg_d;
    logic              cmdFail_q, cmdFail_d;

    // soft-reset storage
    logic [3:0]        ctrl_q, ctrl_d;
    logic              ocFlag_q, ocFlag_d;
    logic              uvFlag_q, uvFlag_d;
    logic              hpHold_q, hpHold_d;
    logic              apbAck_q;
    logic [31:0]       rdata_q;
    logic              slvErr_q;
    erc_pkg::erc_drive_s drive_q, drive_d;

    // bus decode
    wire logic       setupPhase = psel & ~penable;
    wire logic       accessDone = psel & penable & apbAck_q;
    wire logic       wrDone     = accessDone & pwrite;
    wire logic [7:0] addrByte   = 8'(paddr);
    wire logic       hitCtrl    = addrByte == `ERC_OFF_CTRL;
    wire logic       hitHw      = addrByte == `ERC_OFF_HWCTRL;
    wire logic       hitStatus  = addrByte == `ERC_OFF_STATUS;
    wire logic       hitAny     = hitCtrl | hitHw | hitStatus;
    wire logic       wrCtrl     = wrDone & hitCtrl;
    wire logic       wrHw       = wrDone & hitHw;
    wire logic       wrStatus   = wrDone & hitStatus;

    wire logic inNormal   = devMode == erc_pkg::ERC_MODE_NORMAL;
    wire logic inStop     = devMode == erc_pkg::ERC_MODE_STOP;
    wire logic isAlone    = cfg_q == erc_pkg::ERC_CFG_ALONE;
    wire logic isShare    = cfg_q == erc_pkg::ERC_CFG_SHARE;
    wire logic wantOn     = pwdata[`ERC_CTRL_ON_BIT];
    wire logic wantShare  = pwdata[`ERC_HW_SHARE_BIT];

    // mode gating of the output per configuration
    function automatic logic mode_allows(input erc_pkg::erc_cfg_e c, input erc_pkg::erc_mode_e m,
                                         input logic onBit, input logic stopKeep);
        logic r;
        r = 1'b0;
        case (c)
            erc_pkg::ERC_CFG_ALONE: begin
                case (m)
                    erc_pkg::ERC_MODE_INIT,
                    erc_pkg::ERC_MODE_FAILSAFE: r = 1'b0;
                    default:                    r = onBit;
                endcase
            end
            erc_pkg::ERC_CFG_SHARE: begin
                case (m)
                    erc_pkg::ERC_MODE_NORMAL,
                    erc_pkg::ERC_MODE_RESTART: r = 1'b1;
                    erc_pkg::ERC_MODE_STOP:    r = stopKeep;
                    default:                   r = 1'b0;
                endcase
            end
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // configuration selection and locking
    // stand-alone select
    wire logic pickAlone = wrCtrl & wantOn & inNormal;
    wire logic pickShare = wrHw & wantShare;
    wire logic shareChange = isShare & ((wrHw & ~wantShare) | (wrCtrl & wantOn));

    always_comb begin
        cfg_d = cfg_q;
        case (cfg_q)
            erc_pkg::ERC_CFG_NONE: begin
                if (pickShare) begin
                    cfg_d = erc_pkg::ERC_CFG_SHARE;
                end else if (pickAlone && !wrHw) begin
                    cfg_d = erc_pkg::ERC_CFG_ALONE;
                end
            end
            erc_pkg::ERC_CFG_ALONE: cfg_d = erc_pkg::ERC_CFG_ALONE;
            erc_pkg::ERC_CFG_SHARE: cfg_d = erc_pkg::ERC_CFG_SHARE;
            default:                cfg_d = erc_pkg::ERC_CFG_NONE;
        endcase
    end

    assign cmdFail_d = shareChange | (cmdFail_q & ~(wrStatus & pwdata[`ERC_ST_FAIL_BIT]));

    // control register; on bit only takes effect from Normal mode
    always_comb begin
        ctrl_d = ctrl_q;
        if (wrCtrl) begin
            ctrl_d[`ERC_CTRL_VSEL_BIT]    = pwdata[`ERC_CTRL_VSEL_BIT];
            ctrl_d[`ERC_CTRL_STPKEEP_BIT] = pwdata[`ERC_CTRL_STPKEEP_BIT];
            ctrl_d[`ERC_CTRL_UVKEEP_BIT]  = pwdata[`ERC_CTRL_UVKEEP_BIT];
            if (inNormal && !isShare && !(cfg_q == erc_pkg::ERC_CFG_NONE && pickShare)) begin
                ctrl_d[`ERC_CTRL_ON_BIT] = wantOn;
            end
        end
    end

    // output gating
    wire logic modeOk  = mode_allows(cfg_d, devMode, ctrl_d[`ERC_CTRL_ON_BIT], ctrl_d[`ERC_CTRL_STPKEEP_BIT]);
    wire logic uvBlock = sense.supplyUv & ~ctrl_d[`ERC_CTRL_UVKEEP_BIT];
    wire logic nextOn  = modeOk & ~uvBlock;
    wire logic nextAlone = cfg_d == erc_pkg::ERC_CFG_ALONE;

    assign hpHold_d = inStop & nextOn & (sense.baseAboveRise | (hpHold_q & ~sense.baseBelowFall));

    always_comb begin
        drive_d = '0;
        drive_d.outEnable      = nextOn;
        drive_d.outSel3v3      = nextAlone & ctrl_d[`ERC_CTRL_VSEL_BIT];
        drive_d.highPowerStage = nextOn & (inStop ? hpHold_d : 1'b1);
        drive_d.lowPowerStage  = nextOn & inStop;
        // limit in stand-alone; none when sharing
        drive_d.currentLimit   = nextAlone & nextOn & sense.shuntReached;
    end

    // overcurrent flag, clear only once condition gone
    wire logic ocEvent = isAlone & drive_q.outEnable & sense.shuntReached;
    assign ocFlag_d = ocEvent | (ocFlag_q & ~(wrStatus & pwdata[`ERC_ST_OC_BIT] & ~sense.shuntReached));

    wire logic uvEvent = isAlone & drive_q.outEnable & sense.outUv;
    assign uvFlag_d = uvEvent | (uvFlag_q & ~(wrStatus & pwdata[`ERC_ST_UV_BIT]));

    // read mux
    wire logic [31:0] statusWord = {21'h00_0000,
                                    drive_q.lowPowerStage, drive_q.highPowerStage, drive_q.outEnable,
                                    1'b0, isShare, isAlone, cfg_q != erc_pkg::ERC_CFG_NONE,
                                    1'b0, cmdFail_q, uvFlag_q, ocFlag_q};
    wire logic [31:0] readWord =
        hitCtrl   ? {28'h000_0000, ctrl_q} :
        hitHw     ? {31'h0000_0000, isShare} :
        hitStatus ? statusWord : `ERC_RDATA_RESET;

    // power-on domain: soft reset does not touch it
    // power-on only storage
    always_ff @(posedge clk) begin
        if (!porN) begin
            cfg_q     <= erc_pkg::ERC_CFG_NONE;
            cmdFail_q <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            cmdFail_q <= cmdFail_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !porN) begin
            ctrl_q   <= `ERC_CTRL_RESET;
            ocFlag_q <= 1'b0;
            uvFlag_q <= 1'b0;
            hpHold_q <= 1'b0;
            drive_q  <= '0;
        end else begin
            ctrl_q   <= ctrl_d;
            ocFlag_q <= ocFlag_d;
            uvFlag_q <= uvFlag_d;
            hpHold_q <= hpHold_d;
            drive_q  <= drive_d;
        end
    end

    // answer in the first access cycle; data captured in setup
    always_ff @(posedge clk) begin
        if (!resetn || !porN) begin
            apbAck_q <= 1'b0;
            rdata_q  <= `ERC_RDATA_RESET;
            slvErr_q <= 1'b0;
        end else begin
            apbAck_q <= setupPhase;
            if (setupPhase) begin
                rdata_q  <= pwrite ? `ERC_RDATA_RESET : readWord;
                slvErr_q <= ~hitAny;
            end
        end
    end

    assign prdata  = rdata_q;
    assign pready  = apbAck_q;
    assign pslverr = slvErr_q;
    assign drive   = drive_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn || !porN);

    a_cfg_lock_holds: assert property (
        cfg_q != erc_pkg::ERC_CFG_NONE |=> cfg_q == $past(cfg_q))
        else $error("locked configuration changed");

    a_share_fail_set: assert property (
        shareChange |=> cmdFail_q && isShare)
        else $error("share change did not raise command-fail");

    a_alone_no_fail: assert property (
        isAlone && wrHw && !cmdFail_q |=> !cmdFail_q)
        else $error("stand-alone change attempt raised command-fail");

    a_vsel_share_off: assert property (
        isShare |=> !drive_q.outSel3v3)
        else $error("voltage select active while sharing");

    a_init_off: assert property (
        devMode == erc_pkg::ERC_MODE_INIT || devMode == erc_pkg::ERC_MODE_FAILSAFE |=> !drive_q.outEnable)
        else $error("output on in Init or Fail-Safe");

    a_share_sleep_off: assert property (
        isShare && devMode == erc_pkg::ERC_MODE_SLEEP |=> !drive_q.outEnable)
        else $error("sharing output on in Sleep");

    a_share_stop_gate: assert property (
        isShare && inStop && !sense.supplyUv |=> drive_q.outEnable == $past(ctrl_d[`ERC_CTRL_STPKEEP_BIT]))
        else $error("stop-mode sharing gate wrong");

    a_uv_supply_off: assert property (
        sense.supplyUv && !ctrl_d[`ERC_CTRL_UVKEEP_BIT] |=> !drive_q.outEnable)
        else $error("output on during supply undervoltage");

    a_normal_hp_only: assert property (
        inNormal ##1 drive_q.outEnable |-> drive_q.highPowerStage && !drive_q.lowPowerStage)
        else $error("low-power stage in Normal");

    a_share_no_oc: assert property (
        isShare && !ocFlag_q |=> !ocFlag_q && !drive_q.currentLimit)
        else $error("overcurrent while sharing");

    a_share_no_uv: assert property (
        isShare && !uvFlag_q |=> !uvFlag_q)
        else $error("undervoltage flag while sharing");

    a_oc_sticky: assert property (
        ocFlag_q && sense.shuntReached |=> ocFlag_q)
        else $error("overcurrent flag cleared while present");

    a_vsel_alone_pass: assert property (
        isAlone |=> drive_q.outSel3v3 == $past(ctrl_d[`ERC_CTRL_VSEL_BIT]))
        else $error("stand-alone voltage select not applied");

    a_alone_pick: assert property (
        cfg_q == erc_pkg::ERC_CFG_NONE && pickAlone && !wrHw |=> isAlone)
        else $error("stand-alone not selected");

    a_share_pick: assert property (
        cfg_q == erc_pkg::ERC_CFG_NONE && pickShare |=> isShare)
        else $error("load sharing not selected");

    a_share_on_dead: assert property (
        isShare |-> !ctrl_q[`ERC_CTRL_ON_BIT])
        else $error("on bit took effect while sharing");

    a_no_lock_early: assert property (
        cfg_q == erc_pkg::ERC_CFG_NONE && !pickShare && !pickAlone |=> cfg_q == erc_pkg::ERC_CFG_NONE)
        else $error("configuration locked without a select");

    a_alone_switch: assert property (
        isAlone && wrCtrl && inNormal |=> ctrl_q[`ERC_CTRL_ON_BIT] == $past(wantOn))
        else $error("locked stand-alone output not switchable");

    a_fail_only_share: assert property (
        !cmdFail_q && !shareChange |=> !cmdFail_q)
        else $error("command-fail raised without share change");

    a_fail_sticky: assert property (
        cmdFail_q && !wrStatus |=> cmdFail_q)
        else $error("command-fail lost without clear");

    a_alone_hold_mode: assert property (
        isAlone && (devMode == erc_pkg::ERC_MODE_SLEEP || devMode == erc_pkg::ERC_MODE_RESTART)
        && !sense.supplyUv |=> drive_q.outEnable == $past(ctrl_q[`ERC_CTRL_ON_BIT]))
        else $error("stand-alone setting not held");

    a_share_restart_on: assert property (
        isShare && devMode == erc_pkg::ERC_MODE_RESTART && !sense.supplyUv |=> drive_q.outEnable)
        else $error("sharing output off in Restart");

    a_share_resume: assert property (
        isShare && inNormal && !sense.supplyUv |=> drive_q.outEnable)
        else $error("sharing did not resume in Normal");

    a_uv_keep_on: assert property (
        inNormal && isAlone && ctrl_d[`ERC_CTRL_ON_BIT] && ctrl_d[`ERC_CTRL_UVKEEP_BIT] |=> drive_q.outEnable)
        else $error("keep-on bit did not hold output");

    a_stop_hp_rise: assert property (
        inStop && sense.baseAboveRise && drive_d.outEnable |=> drive_q.highPowerStage && drive_q.lowPowerStage)
        else $error("high-power stage not added in Stop");

    a_stop_hp_fall: assert property (
        inStop && sense.baseBelowFall && !sense.baseAboveRise |=> !drive_q.highPowerStage)
        else $error("high-power stage not dropped in Stop");

    a_oc_set_alone: assert property (
        isAlone && drive_q.outEnable && sense.shuntReached |=> ocFlag_q)
        else $error("overcurrent flag not set");

    a_limit_alone: assert property (
        nextAlone && nextOn && sense.shuntReached |=> drive_q.currentLimit)
        else $error("current limit not applied");

    a_uv_set_alone: assert property (
        isAlone && drive_q.outEnable && sense.outUv |=> uvFlag_q)
        else $error("output undervoltage flag not set");

    a_uv_only_alone: assert property (
        !isAlone && !uvFlag_q |=> !uvFlag_q)
        else $error("undervoltage flag outside stand-alone");

    a_share_fs_off: assert property (
        isShare && devMode == erc_pkg::ERC_MODE_FAILSAFE |=> !drive_q.outEnable)
        else $error("sharing output on in Fail-Safe");

    a_ready_single: assert property (
        pready |=> !pready)
        else $error("pready stood longer than one cycle");

endmodule // erc_ctrl

`default_nettype wire

// file: erc_params.svh
`ifndef ERC_PARAMS_SVH
`define ERC_PARAMS_SVH

// register byte offsets
`define ERC_OFF_CTRL        8'h00
`define ERC_OFF_HWCTRL      8'h04
`define ERC_OFF_STATUS      8'h08

// control register fields
`define ERC_CTRL_ON_BIT     0
`define ERC_CTRL_VSEL_BIT   1
`define ERC_CTRL_STPKEEP_BIT 2
`define ERC_CTRL_UVKEEP_BIT 3

// hardware control register fields
`define ERC_HW_SHARE_BIT    0

// status register fields
`define ERC_ST_OC_BIT       0
`define ERC_ST_UV_BIT       1
`define ERC_ST_FAIL_BIT     2
`define ERC_ST_LOCK_BIT     4
`define ERC_ST_ALONE_BIT    5
`define ERC_ST_SHARE_BIT    6
`define ERC_ST_OUTEN_BIT    8
`define ERC_ST_HP_BIT       9
`define ERC_ST_LP_BIT       10

// reset values
`define ERC_CTRL_RESET      4'h0
`define ERC_RDATA_RESET     32'h0000_0000

`endif

// file: erc_pkg.sv
package erc_pkg;

    // operating mode of the surrounding device
    typedef enum logic [2:0] {
        ERC_MODE_INIT,
        ERC_MODE_NORMAL,
        ERC_MODE_STOP,
        ERC_MODE_SLEEP,
        ERC_MODE_RESTART,
        ERC_MODE_FAILSAFE
    } erc_mode_e;

    // configuration of the external output
    typedef enum logic [1:0] {
        ERC_CFG_NONE,
        ERC_CFG_ALONE,
        ERC_CFG_SHARE
    } erc_cfg_e;

    // analog comparator results
    typedef struct packed {
        logic supplyUv;
        logic baseAboveRise;
        logic baseBelowFall;
        logic shuntReached;
        logic outUv;
    } erc_sense_s;

    // controls to the regulator stages
    typedef struct packed {
        logic outEnable;
        logic outSel3v3;
        logic highPowerStage;
        logic lowPowerStage;
        logic currentLimit;
    } erc_drive_s;

endpackage : erc_pkg

// file: erc_load_model.sv
`timescale 1ns/10ps
`default_nettype none

module erc_load_model (
    // regulator controls from the block
    input  wire erc_pkg::erc_drive_s drive,
    // load conditions chosen by the bench
    input  wire logic                loadHigh,
    input  wire logic                shortOut,
    input  wire logic                supplyLow,
    input  wire logic                outLow,
    // comparator results
    output var  erc_pkg::erc_sense_s sense
);
    // base and shunt current only flow while the pass device is driven
    wire logic driven = drive.outEnable;

    // rise and fall comparators are complementary while driven: the hysteresis band is not modelled
    assign sense.baseAboveRise = driven & loadHigh;
    assign sense.baseBelowFall = driven & ~loadHigh;
    assign sense.shuntReached  = driven & shortOut;
    assign sense.outUv         = driven & outLow;
    assign sense.supplyUv      = supplyLow;
endmodule // erc_load_model

`default_nettype wire

// file: tb_ext_regulator_config_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "erc_params.svh"

module tb_ext_regulator_config_control;
    localparam logic [31:0] ONE  = 32'h0000_0001;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic                clk       = 1'b0;
    logic                resetn    = 1'b0;
    logic                porN      = 1'b0;
    logic                psel      = 1'b0;
    logic                penable   = 1'b0;
    logic                pwrite    = 1'b0;
    logic [7:0]          paddr     = 8'h00;
    logic [31:0]         pwdata    = 32'h0000_0000;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    erc_pkg::erc_mode_e  devMode   = erc_pkg::ERC_MODE_INIT;
    erc_pkg::erc_sense_s sense;
    erc_pkg::erc_drive_s drive;
    logic                loadHigh  = 1'b0;
    logic                shortOut  = 1'b0;
    logic                supplyLow = 1'b0;
    logic                outLow    = 1'b0;
    logic [31:0]         rd;
    logic                er;
    int                  miscompares = 0;
    int                  cmpCount    = 0;
    erc_pkg::erc_mode_e  modeTab[4]  = '{erc_pkg::ERC_MODE_INIT, erc_pkg::ERC_MODE_SLEEP,
                                         erc_pkg::ERC_MODE_RESTART, erc_pkg::ERC_MODE_FAILSAFE};
    logic                expTab[4]   = '{1'b0, 1'b0, 1'b1, 1'b0};

    always #25 clk = ~clk;

    erc_ctrl erc_ctrl_inst (.clk(clk), .resetn(resetn), .porN(porN), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .devMode(devMode), .sense(sense), .drive(drive));
    erc_load_model erc_load_model_inst (.drive(drive), .loadHigh(loadHigh), .shortOut(shortOut),
        .supplyLow(supplyLow), .outLow(outLow), .sense(sense));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // one apb transfer; the request stands until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // look mid-cycle so the values seen are those the completing edge samples
        do begin
            @(negedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) miscompares++;
        rd = prdata;
        er = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt;
        repeat (3) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] v);
        xfer(1'b1, a, {28'h000_0000, v});
        wt();
    endtask

    task automatic rs;
        xfer(1'b0, `ERC_OFF_STATUS, ZERO);
    endtask

    task automatic go(input erc_pkg::erc_mode_e m);
        @(posedge clk);
        devMode <= m;
        wt();
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        porN <= 1'b1;
        @(posedge clk);
        chk(32'(drive), ZERO);
        xfer(1'b0, 8'h0C, ZERO);
        chk(32'(er), ONE);
        chk(rd, ZERO);
        wr(`ERC_OFF_CTRL, 4'h1);
        rs();
        chk(32'(rd[5:4]), ZERO); // not in init
        go(erc_pkg::ERC_MODE_NORMAL);
        wr(`ERC_OFF_CTRL, 4'h3);
        chk(32'(drive.outSel3v3), ONE); // 3v3
        chk(32'(drive.highPowerStage), ONE); // hp only
        chk(32'(drive.lowPowerStage), ZERO); // hp only
        rs();
        chk(32'(rd[6:4]), 32'h0000_0003); // locked alone
        wr(`ERC_OFF_CTRL, 4'h1);
        chk(32'(drive.outSel3v3), ZERO); // 5v
        wr(`ERC_OFF_HWCTRL, 4'h1);
        rs();
        chk(32'(rd[6:2]), 32'h0000_000C); // silent ignore
        wr(`ERC_OFF_CTRL, 4'h0);
        chk(32'(drive.outEnable), ZERO); // still off
        wr(`ERC_OFF_CTRL, 4'h1);
        chk(32'(drive.outEnable), ONE); // still on
        @(posedge clk) shortOut <= 1'b1;
        wt();
        chk(32'(drive.currentLimit), ONE); // limit
        chk(32'(drive.outEnable), ONE); // no reaction
        xfer(1'b1, `ERC_OFF_STATUS, ONE);
        rs();
        chk(32'(rd[0]), ONE); // sticky
        @(posedge clk) shortOut <= 1'b0;
        wt();
        xfer(1'b1, `ERC_OFF_STATUS, ONE);
        rs();
        chk(32'(rd[0]), ZERO); // cleared
        @(posedge clk) outLow <= 1'b1;
        wt();
        rs();
        chk(32'(rd[1]), ONE); // uv flag
        @(posedge clk) outLow <= 1'b0;
        @(posedge clk) supplyLow <= 1'b1;
        wt();
        chk(32'(drive.outEnable), ZERO); // off
        @(posedge clk) supplyLow <= 1'b0;
        wt();
        chk(32'(drive.outEnable), ONE); // recover
        wr(`ERC_OFF_CTRL, 4'h9);
        @(posedge clk) supplyLow <= 1'b1;
        wt();
        chk(32'(drive.outEnable), ONE); // keep on
        @(posedge clk) supplyLow <= 1'b0;
        go(erc_pkg::ERC_MODE_STOP);
        chk(32'(drive.outEnable), ONE); // fixed
        @(posedge clk) loadHigh <= 1'b1;
        wt();
        chk(32'(drive.highPowerStage), ONE); // add hp
        @(posedge clk) loadHigh <= 1'b0;
        wt();
        chk(32'(drive.highPowerStage), ZERO); // drop hp
        chk(32'(drive.lowPowerStage), ONE); // lp
        for (int i = 0; i < 4; i++) begin
            go(modeTab[i]);
            chk(32'(drive.outEnable), 32'(i == 1 || i == 2)); // by mode
        end
        @(posedge clk) resetn <= 1'b0;
        @(posedge clk) resetn <= 1'b1;
        rs();
        chk(32'(rd[5:4]), 32'h0000_0003); // soft reset
        @(posedge clk) porN <= 1'b0;
        @(posedge clk) porN <= 1'b1;
        go(erc_pkg::ERC_MODE_NORMAL);
        wr(`ERC_OFF_HWCTRL, 4'h1);
        wr(`ERC_OFF_CTRL, 4'h6);
        chk(32'(drive.outEnable), ONE); // sharing
        chk(32'(drive.outSel3v3), ZERO); // vsel ignored
        @(posedge clk) shortOut <= 1'b1;
        @(posedge clk) outLow <= 1'b1;
        wt();
        chk(32'(drive.currentLimit), ZERO); // no limit
        rs();
        chk(32'(rd[6:0]), 32'h0000_0050); // no flags
        @(posedge clk) shortOut <= 1'b0;
        @(posedge clk) outLow <= 1'b0;
        wr(`ERC_OFF_HWCTRL, 4'h0);
        rs();
        chk(32'(rd[6:2]), 32'h0000_0015); // fail kept
        go(erc_pkg::ERC_MODE_STOP);
        chk(32'(drive.outEnable), ONE); // keep in stop
        go(erc_pkg::ERC_MODE_NORMAL);
        wr(`ERC_OFF_CTRL, 4'h2);
        go(erc_pkg::ERC_MODE_STOP);
        chk(32'(drive.outEnable), ZERO); // off in stop
        xfer(1'b0, `ERC_OFF_HWCTRL, ZERO);
        chk(32'(rd[0]), ONE); // bit stays
        go(erc_pkg::ERC_MODE_NORMAL);
        chk(32'(drive.outEnable), ONE); // resumes
        for (int i = 0; i < 4; i++) begin
            go(modeTab[i]);
            chk(32'(drive.outEnable), 32'(expTab[i])); // by mode
        end
        print_verdict();
    end
endmodule // tb_ext_regulator_config_control

`default_nettype wire
